// ==== hdl/apbtmr_consts.vh ====
// Constants for the APB down-counting timer: offsets, control bit positions,
// reset values and identification values.
// Assumes inclusion by bare name from the timer's design files.
`ifndef APBTMR_CONSTS_VH
`define APBTMR_CONSTS_VH

// ****************
// Register offsets
// ****************
`define APBTMR_OFF_CTRL 12'h000
`define APBTMR_OFF_COUNT 12'h004
`define APBTMR_OFF_RELOAD 12'h008
`define APBTMR_OFF_IRQ 12'h00C
`define APBTMR_OFF_PERIPH_IDENT_4 12'hFD0
`define APBTMR_OFF_PERIPH_IDENT_5 12'hFD4
`define APBTMR_OFF_PERIPH_IDENT_6 12'hFD8
`define APBTMR_OFF_PERIPH_IDENT_7 12'hFDC
`define APBTMR_OFF_PID0 12'hFE0
`define APBTMR_OFF_PERIPH_IDENT_1 12'hFE4
`define APBTMR_OFF_PERIPH_IDENT_2 12'hFE8
`define APBTMR_OFF_PERIPH_IDENT_3 12'hFEC
`define APBTMR_OFF_COMPONENT_IDENT_1 12'hFF4
`define APBTMR_OFF_COMPONENT_IDENT_2 12'hFF8
`define APBTMR_OFF_COMPONENT_IDENT_3 12'hFFC

// ****************
// Control fields
// ****************
`define APBTMR_CTRL_EN 0
`define APBTMR_CTRL_EXT_EN 1
`define APBTMR_CTRL_EXT_CLK 2
`define APBTMR_CTRL_IRQ_EN 3
`define APBTMR_CTRL_W 4

// ****************
// Reset values
// ****************
`define APBTMR_RST_CTRL 4'h0
`define APBTMR_RST_WORD 32'h00000000

// ****************
// Identification values (arbitrary, neutral)
// ****************
`define APBTMR_ID_PERIPH_IDENT_4 32'h00000000
`define APBTMR_ID_PERIPH_IDENT_5 32'h00000000
`define APBTMR_ID_PERIPH_IDENT_6 32'h00000000
`define APBTMR_ID_PERIPH_IDENT_7 32'h00000000
`define APBTMR_ID_PID0 32'h00000011
`define APBTMR_ID_PERIPH_IDENT_1 32'h00000022
`define APBTMR_ID_PERIPH_IDENT_2 32'h00000033
`define APBTMR_ID_PERIPH_IDENT_3 32'h00000000
`define APBTMR_ID_COMPONENT_IDENT_1 32'h00000044
`define APBTMR_ID_COMPONENT_IDENT_2 32'h00000055
`define APBTMR_ID_COMPONENT_IDENT_3 32'h00000066

`endif

// ==== hdl/apbtmr_edge_sync.v ====
// Two-stage synchroniser and rising-edge detector for the external input.
// Assumes i_async comes from outside the i_clk domain.
`timescale 1ns/1ps

module apbtmr_edge_sync (
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_async,
  output wire o_level,
  output wire o_rise
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // ****************
  // Synchroniser; first stage feeds only the second
  // ****************
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (i_ce) begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~prev_reg;

endmodule // apbtmr_edge_sync

// ==== hdl/apbtmr_top.v ====
// APB down-counting timer: 32-bit counter with reload, held interrupt
// request, external gate or clock input, and identification registers.
// Assumes an APB3 master on i_clk; external input is asynchronous.
//
// How it works
// - A 32-bit count decrements toward zero and is reached over the APB bus.
// - The interrupt status is set whenever the count steps down from 1 to zero; a bus write of zero does not set it.
// - The status stays set until software writes the clear register at 0x00C; clearing ctrl_irq_en only masks the output.
// - With external enabling, a rising edge on the external input arms counting, which then runs only while the input is high.
// - A zero event in the same cycle as a clear leaves the status set.
// - The external input passes two flip-flops and an edge detector first.
// - Fifteen registers: control, count, reload, status/clear, and identification.
`timescale 1ns/1ps
`include "apbtmr_consts.vh"

module apbtmr_top (
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire i_external_gate_input,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg o_timer_irq_out
);
  // ****************
  // State
  // ****************
  reg [`APBTMR_CTRL_W-1:0] ctrl_reg;
  reg [31:0] count_reg;
  reg [31:0] reload_reg;
  reg irq_status_reg;
  reg ext_armed_reg;
  reg [31:0] count_next;
  reg [31:0] rdata_next;
  reg irq_status_next;
  reg ext_armed_next;
  reg tick;
  reg zero_event;
  reg pready_reg;
  reg pslverr_reg;

  wire ext_level;
  wire ext_rise;
  wire wr_en;
  wire rd_en;
  wire ctrl_en;
  wire ctrl_ext_en;
  wire ctrl_ext_clk;
  wire ctrl_irq_en;
  wire wr_ctrl;
  wire wr_count;
  wire wr_reload;
  wire wr_irq;
  wire irq_en_next;

  // ****************
  // External input synchroniser
  // ****************
  apbtmr_edge_sync u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(i_external_gate_input),
    .o_level(ext_level),
    .o_rise(ext_rise)
  );

  // ****************
  // Bus decode and response
  // ****************
  // Zero-wait slave; every access completes in the access phase
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign wr_ctrl = wr_en & (i_paddr == `APBTMR_OFF_CTRL);
  assign wr_count = wr_en & (i_paddr == `APBTMR_OFF_COUNT);
  assign wr_reload = wr_en & (i_paddr == `APBTMR_OFF_RELOAD);
  assign wr_irq = wr_en & (i_paddr == `APBTMR_OFF_IRQ);
  // Mask follows a control write at the same edge, so no stale output cycle
  assign irq_en_next = wr_ctrl ? i_pwdata[`APBTMR_CTRL_IRQ_EN] : ctrl_irq_en;

  // Flops, so that every top output leaves a register
  always @(posedge i_clk) begin
    if (i_reset) begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
    end else if (i_ce) begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
    end
  end

  // ****************
  // Control fields
  // ****************
  assign ctrl_en = ctrl_reg[`APBTMR_CTRL_EN];
  assign ctrl_ext_en = ctrl_reg[`APBTMR_CTRL_EXT_EN];
  assign ctrl_ext_clk = ctrl_reg[`APBTMR_CTRL_EXT_CLK];
  assign ctrl_irq_en = ctrl_reg[`APBTMR_CTRL_IRQ_EN];

  // ****************
  // Counter
  // ****************
  always @* begin
    ext_armed_next = ext_armed_reg;
    if (!ctrl_en || !ctrl_ext_en) begin
      ext_armed_next = 1'b0;
    end else if (ext_rise) begin
      ext_armed_next = 1'b1;
    end
    // External gate counts only after its rising edge has armed it
    if (!ctrl_en) begin
      tick = 1'b0;
    end else if (ctrl_ext_clk) begin
      tick = ext_rise;
    end else if (ctrl_ext_en) begin
      tick = ext_armed_reg & ext_level;
    end else begin
      tick = 1'b1;
    end
  end

  // ****************
  // Count and status
  // ****************
  always @* begin
    zero_event = 1'b0;
    count_next = count_reg;
    if (tick) begin
      if (count_reg == 32'h00000001 || count_reg == 32'h00000000) begin
        zero_event = (count_reg == 32'h00000001);
        count_next = (count_reg == 32'h00000000) ? reload_reg : 32'h00000000;
      end else begin
        count_next = count_reg - 32'h00000001;
      end
    end
    if (wr_count) begin
      count_next = i_pwdata;
    end
    // Set wins over clear
    irq_status_next = irq_status_reg;
    if (wr_irq) begin
      irq_status_next = 1'b0;
    end
    if (zero_event) begin
      irq_status_next = 1'b1;
    end
  end

  // ****************
  // Read mux
  // ****************
  always @* begin
    case (i_paddr)
      `APBTMR_OFF_CTRL: rdata_next = {28'h0000000, ctrl_reg};
      `APBTMR_OFF_COUNT: rdata_next = count_reg;
      `APBTMR_OFF_RELOAD: rdata_next = reload_reg;
      `APBTMR_OFF_IRQ: rdata_next = {31'h00000000, irq_status_reg};
      // Identification words are fixed; no write path reaches them
      `APBTMR_OFF_PERIPH_IDENT_4: rdata_next = `APBTMR_ID_PERIPH_IDENT_4;
      `APBTMR_OFF_PERIPH_IDENT_5: rdata_next = `APBTMR_ID_PERIPH_IDENT_5;
      `APBTMR_OFF_PERIPH_IDENT_6: rdata_next = `APBTMR_ID_PERIPH_IDENT_6;
      `APBTMR_OFF_PERIPH_IDENT_7: rdata_next = `APBTMR_ID_PERIPH_IDENT_7;
      `APBTMR_OFF_PID0: rdata_next = `APBTMR_ID_PID0;
      `APBTMR_OFF_PERIPH_IDENT_1: rdata_next = `APBTMR_ID_PERIPH_IDENT_1;
      `APBTMR_OFF_PERIPH_IDENT_2: rdata_next = `APBTMR_ID_PERIPH_IDENT_2;
      `APBTMR_OFF_PERIPH_IDENT_3: rdata_next = `APBTMR_ID_PERIPH_IDENT_3;
      `APBTMR_OFF_COMPONENT_IDENT_1: rdata_next = `APBTMR_ID_COMPONENT_IDENT_1;
      `APBTMR_OFF_COMPONENT_IDENT_2: rdata_next = `APBTMR_ID_COMPONENT_IDENT_2;
      `APBTMR_OFF_COMPONENT_IDENT_3: rdata_next = `APBTMR_ID_COMPONENT_IDENT_3;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // ****************
  // Counter state
  // ****************
  always @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= `APBTMR_RST_WORD;
      irq_status_reg <= 1'b0;
      ext_armed_reg <= 1'b0;
      o_timer_irq_out <= 1'b0;
    end else if (i_ce) begin
      count_reg <= count_next;
      irq_status_reg <= irq_status_next;
      ext_armed_reg <= ext_armed_next;
      // Masking the output never loses the held status underneath
      o_timer_irq_out <= irq_status_next & irq_en_next;
    end
  end

  // ****************
  // Bus registers
  // ****************
  always @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_reg <= `APBTMR_RST_CTRL;
      reload_reg <= `APBTMR_RST_WORD;
      o_prdata <= `APBTMR_RST_WORD;
    end else if (i_ce) begin
      // Data registered in setup phase so it is valid in access phase
      if (rd_en) begin
        o_prdata <= rdata_next;
      end
      if (wr_ctrl) begin
        ctrl_reg <= i_pwdata[`APBTMR_CTRL_W-1:0];
      end
      if (wr_reload) begin
        reload_reg <= i_pwdata;
      end
    end
  end

endmodule // apbtmr_top

// ==== sim/apbtmr_monitor.sv ====
// Checker on the timer's top ports.
// Assumes it is bound to apbtmr_top.
`timescale 1ns/1ps
`include "apbtmr_consts.vh"
module apbtmr_monitor (
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_timer_irq_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire rs = i_psel && !i_penable && !i_pwrite && i_ce;
  wire ws = i_psel && i_penable && i_pwrite && (i_paddr == `APBTMR_OFF_IRQ || i_paddr == `APBTMR_OFF_CTRL);
  chk_reset_clears: assert property (disable iff (1'b0) i_reset && i_ce |=> !o_timer_irq_out && o_prdata == 0)
    else $error("reset left state");
  chk_ready_high: assert property (o_pready)
    else $error("wait state");
  chk_no_error: assert property (!o_pslverr)
    else $error("slave error");
  chk_irq_holds: assert property (o_timer_irq_out && !ws |=> o_timer_irq_out)
    else $error("irq dropped");
  chk_rdata_hold: assert property (!rs |=> $stable(o_prdata))
    else $error("rdata moved");
  chk_ident_read: assert property (rs && i_paddr == `APBTMR_OFF_PID0 |=> o_prdata == `APBTMR_ID_PID0)
    else $error("bad ident");
  chk_gap_zero: assert property (rs && i_paddr == 12'hFF0 |=> o_prdata == 32'h0)
    else $error("gap not zero");
  chk_status_width: assert property (rs && i_paddr == `APBTMR_OFF_IRQ |=> o_prdata[31:1] == 31'h0)
    else $error("status wide");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_timer_irq_out) && $stable(o_prdata))
    else $error("state moved while frozen");
endmodule // apbtmr_monitor
bind apbtmr_top apbtmr_monitor apbtmr_monitor_i (.i_clk, .i_reset, .i_ce, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_timer_irq_out);

// ==== sim/apbtmr_ext_src.sv ====
// Source on the external input: slow clean pulses.
// Assumes the timer's clock; the pin rests low between bursts.
`timescale 1ns/1ps
module apbtmr_ext_src (
  input wire i_clk,
  output logic o_pin
);
  initial o_pin = 1'b0;
  task pulse(input int n);
    repeat (n) begin
      @(posedge i_clk) #1 o_pin = 1'b1;
      repeat (3) @(posedge i_clk);
      #1 o_pin = 1'b0;
      repeat (3) @(posedge i_clk);
    end
    #1;
  endtask
endmodule // apbtmr_ext_src

// ==== sim/testbench.sv ====
// Bench: register, counter, irq and external input tests.
// Assumes apbtmr_top, its bound checker and the pulse source.
`timescale 1ns/1ps
`include "apbtmr_consts.vh"
module testbench;
  logic i_clk = '0, i_reset = '1, i_ce = '1, i_psel = '0, i_penable = '0, i_pwrite = '0, watch = '0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, v;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_timer_irq_out, i_external_gate_input;
  int mismatches = 0, n_compared = 0, cyc = 0, drops = 0, d0 = 0, i;
  apbtmr_top apbtmr_top_i (.i_clk, .i_reset, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_external_gate_input, .o_prdata, .o_pready, .o_pslverr, .o_timer_irq_out);
  apbtmr_ext_src apbtmr_ext_src_i (.i_clk, .o_pin(i_external_gate_input));
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (watch && o_timer_irq_out !== 1'b1) drops++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task get(input logic [11:0] a);
    i_psel = 1; i_penable = 0; i_pwrite = 0; i_paddr = a;
    @(posedge i_clk) #1 i_penable = 1;
    @(posedge i_clk) v = o_prdata;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    get(a);
    chk($sformatf("rd %h", a), v, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_psel = 1; i_penable = 0; i_pwrite = 1; i_paddr = a; i_pwdata = d;
    @(posedge i_clk) #1 i_penable = 1;
    @(posedge i_clk) #1;
  endtask
  task idle(input int n);
    i_psel = 0; i_penable = 0;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_reset = 0;
    for (i = 0; i < 16; i += 4) rd(i[11:0], 32'h0);
    wr(`APBTMR_OFF_COMPONENT_IDENT_2, 32'hFFFFFFFF);
    wr(12'hFF0, 32'h1);
    rd(`APBTMR_OFF_COMPONENT_IDENT_2, `APBTMR_ID_COMPONENT_IDENT_2);
    rd(12'hFF0, 32'h0);
    $display("registers done");
    wr(`APBTMR_OFF_RELOAD, 32'h100);
    wr(`APBTMR_OFF_COUNT, 32'h3);
    rd(`APBTMR_OFF_COUNT, 32'h3);
    wr(`APBTMR_OFF_CTRL, 32'h9);
    idle(1);
    for (i = 0; i < 20 && o_timer_irq_out !== 1'b1; i++) @(posedge i_clk) #1;
    chk("irq", o_timer_irq_out, 1'b1);
    rd(`APBTMR_OFF_IRQ, 32'h1);
    get(`APBTMR_OFF_COUNT);
    chk("reload", v > 32'hF0 && v <= 32'h100, 1'b1);
    wr(`APBTMR_OFF_CTRL, 32'h8);
    idle(5);
    chk("irq held", o_timer_irq_out, 1'b1);
    wr(`APBTMR_OFF_IRQ, 32'h0);
    idle(1);
    chk("irq clear", o_timer_irq_out, 1'b0);
    rd(`APBTMR_OFF_IRQ, 32'h0);
    $display("counter done");
    // Reload 1 gives a zero event every other cycle
    wr(`APBTMR_OFF_RELOAD, 32'h1);
    wr(`APBTMR_OFF_COUNT, 32'h1);
    wr(`APBTMR_OFF_CTRL, 32'h9);
    idle(8);
    for (int p = 0; p < 2; p++) begin
      // One idle plus four writes is nine edges, an odd phase shift per pass
      idle(1);
      drops = 0;
      watch = 1;
      repeat (4) wr(`APBTMR_OFF_IRQ, 32'h0);
      watch = 0;
      if (p == 0) d0 = drops;
    end
    chk("race", (d0 == 0) != (drops == 0), 1'b1);
    $display("race done");
    wr(`APBTMR_OFF_CTRL, 32'h0);
    wr(`APBTMR_OFF_COUNT, 32'h10);
    wr(`APBTMR_OFF_CTRL, 32'h5);
    apbtmr_ext_src_i.pulse(4);
    idle(4);
    rd(`APBTMR_OFF_COUNT, 32'hC);
    wr(`APBTMR_OFF_CTRL, 32'h0);
    wr(`APBTMR_OFF_COUNT, 32'h20);
    wr(`APBTMR_OFF_CTRL, 32'h3);
    idle(6);
    rd(`APBTMR_OFF_COUNT, 32'h20);
    apbtmr_ext_src_i.pulse(1);
    idle(4);
    get(`APBTMR_OFF_COUNT);
    chk("gated", v < 32'h20 && v > 32'h18, 1'b1);
    $display("external done");
    wr(`APBTMR_OFF_CTRL, 32'h0);
    wr(`APBTMR_OFF_COUNT, 32'h80);
    wr(`APBTMR_OFF_CTRL, 32'h1);
    i_ce = 0;
    idle(10);
    i_ce = 1;
    rd(`APBTMR_OFF_COUNT, 32'h80);
    rd(`APBTMR_OFF_COUNT, 32'h7E);
    i_reset = 1;
    idle(2);
    i_reset = 0;
    rd(`APBTMR_OFF_COUNT, 32'h0);
    rd(`APBTMR_OFF_IRQ, 32'h0);
    $display("freeze and reset done");
    wrap_up;
  end
endmodule // testbench
